// [pkg/pdcap_defines.vh]
// Notes on behaviour
// (R1) The attention lamp present capability bit 13 is read-only and always reads zero.
// (R2) The power lamp present capability bit 14 is read-only and always reads zero.
// (R3) The role-based error support capability bit 15 is read-only and always reads one; a read with a same-cycle capabilities write returns zero.
// (R4) On an upstream port a slot power limit message loads value into bits 25:18, scale into 27:26.
// (R5) The captured scale code means 1.0x, 0.1x, 0.01x and 0.001x for codes 0 to 3.
// (R6) A port in unattached mode keeps its captured power fields when such a message arrives.
// (R7) The captured power fields read zero on downstream ports and on unattached ports.
// (R8) One slot power limit message updates the captured fields of every function of the port.
// (R9) Control bit 0 is a read-write enable, reset to zero, gating correctable error reports.
// (R10) Control bit 1 is a read-write enable, reset to zero, gating non-fatal error reports.
// (R11) Control bit 2 is a read-write enable, reset to zero, gating fatal error reports.
// (R12) The port type code tells upstream from downstream and decides whether capture applies.
// (R13) Writes to read-only capability fields are ignored and reserved capability bits read zero; the code also clears cfg_rdata on such a write.
`ifndef PDCAP_DEFINES_VH
`define PDCAP_DEFINES_VH

`define PDCAP_ADDR_W           12
`define PDCAP_OFF_DEVCAP       12'h044
`define PDCAP_OFF_DEVCTL       12'h048

`define PDCAP_BIT_ATTN_LAMP    13
`define PDCAP_BIT_PWR_LAMP     14
`define PDCAP_BIT_ROLE_ERR     15
`define PDCAP_CPV_LSB          18
`define PDCAP_CPV_MSB          25
`define PDCAP_CPS_LSB          26
`define PDCAP_CPS_MSB          27
`define PDCAP_LOW_CAP_W        13

`define PDCAP_ATTN_LAMP_VAL    1'h0
`define PDCAP_PWR_LAMP_VAL     1'h0
`define PDCAP_ROLE_ERR_VAL     1'h1

`define PDCAP_BIT_CORR_EN      0
`define PDCAP_BIT_NONFATAL_EN  1
`define PDCAP_BIT_FATAL_EN     2
`define PDCAP_DEVCTL_RESET     3'h0
`define PDCAP_DEVCTL_W         16

`define PDCAP_TYPE_UPSTREAM    4'h5
`define PDCAP_TYPE_DOWNSTREAM  4'h6

`define PDCAP_SCALE_X1         2'h0
`define PDCAP_SCALE_X0P1       2'h1
`define PDCAP_SCALE_X0P01      2'h2
`define PDCAP_SCALE_X0P001     2'h3

`define PDCAP_VALUE_W          8
`define PDCAP_SCALE_W          2
`define PDCAP_CAPT_W           10

`endif

// [hw/pdcap_spl_capture.v]
`timescale 1ns/10ps
`include "pdcap_defines.vh"

module pdcap_spl_capture #(
   parameter NUM_FUNC = 1
) (
   input  wire                                 sys_clk,       // core clock
   input  wire                                 reset_n,       // async reset, active low
   input  wire                                 msg_valid,     // power limit message strobe
   input  wire [`PDCAP_VALUE_W-1:0]            msg_value,     // message power value
   input  wire [`PDCAP_SCALE_W-1:0]            msg_scale,     // message power scale
   input  wire                                 capture_allow, // upstream and attached
   output wire [NUM_FUNC*`PDCAP_CAPT_W-1:0]    capt_flat,     // {scale,value} per function
   output reg                                  captured_r     // pulse after an update
);

   reg [`PDCAP_CAPT_W-1:0] capt_mem_r [0:NUM_FUNC-1];
   integer i;

   // one message reaches every function of the port at once
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (i = 0; i < NUM_FUNC; i = i + 1) begin
            capt_mem_r[i] <= {`PDCAP_CAPT_W{1'b0}};
         end
         captured_r <= 1'b0;
      end else begin
         captured_r <= msg_valid & capture_allow;
         if (msg_valid && capture_allow) begin // [R4] [R6] [R12]
            for (i = 0; i < NUM_FUNC; i = i + 1) begin
               capt_mem_r[i] <= {msg_scale, msg_value}; // [R8]
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_FUNC; g = g + 1) begin : g_flat
         assign capt_flat[g*`PDCAP_CAPT_W +: `PDCAP_CAPT_W] = capt_mem_r[g];
      end
   endgenerate

endmodule // pdcap_spl_capture

// [hw/pdcap_err_gate.v]
`timescale 1ns/10ps
`include "pdcap_defines.vh"

module pdcap_err_gate (
   input  wire       sys_clk,          // core clock
   input  wire       reset_n,          // async reset, active low
   input  wire [2:0] report_enable,    // {fatal, nonfatal, correctable}
   input  wire [2:0] err_event,        // detected error pulses, same order
   output reg  [2:0] err_report_r      // reported error pulses, same order
);

   // an error is reported only while its class is enabled
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         err_report_r <= 3'h0;
      end else begin
         err_report_r <= err_event & report_enable; // [R9] [R10] [R11]
      end
   end

endmodule // pdcap_err_gate

// [hw/pdcap_port_regs.v]
`timescale 1ns/10ps
`include "pdcap_defines.vh"

module pdcap_port_regs #(
   parameter                        NUM_FUNC = 1,
   parameter                        FUNC_W   = 1,
   parameter [`PDCAP_LOW_CAP_W-1:0] LOW_CAP  = 13'h0000
) (
   input  wire                        sys_clk,              // core clock, 200 MHz
   input  wire                        reset_n,              // async reset, active low
   input  wire [`PDCAP_ADDR_W-1:0]    cfg_addr,             // register byte address
   input  wire [FUNC_W-1:0]           cfg_func,             // function number of access
   input  wire [31:0]                 cfg_wdata,            // write data
   input  wire                        cfg_wr,               // write strobe
   input  wire                        cfg_rd,               // read strobe
   output reg  [31:0]                 cfg_rdata,            // read data, cycle after strobe
   input  wire [3:0]                  port_type,            // port type code of this port
   input  wire                        unattached,           // port in unattached mode
   input  wire                        spl_msg_valid,        // power limit message received
   input  wire [`PDCAP_VALUE_W-1:0]   spl_msg_value,        // message power value
   input  wire [`PDCAP_SCALE_W-1:0]   spl_msg_scale,        // message power scale
   input  wire                        err_corr_evt,         // correctable error detected
   input  wire                        err_nonfatal_evt,     // non-fatal error detected
   input  wire                        err_fatal_evt,        // fatal error detected
   output wire                        corr_report,          // correctable error reported
   output wire                        nonfatal_report,      // non-fatal error reported
   output wire                        fatal_report,         // fatal error reported
   output wire                        spl_captured,         // pulse after a capture
   output reg  [`PDCAP_VALUE_W-1:0]   captured_power_value, // function 0 value as read
   output reg  [`PDCAP_SCALE_W-1:0]   captured_power_scale, // function 0 scale as read
   output reg  [14:0]                 power_limit_centi     // function 0 limit, 0.01 W units
);

   function addr_hit;
      input [`PDCAP_ADDR_W-1:0] addr;
      input [`PDCAP_ADDR_W-1:0] offset;
      begin
         addr_hit = (addr == offset);
      end
   endfunction

   // builds the capabilities word for one function's captured fields
   function [31:0] devcap_word;
      input [`PDCAP_CAPT_W-1:0] capt;
      input                     show;
      reg   [31:0]              w;
      begin
         w = 32'h0000_0000; // [R13]
         w[`PDCAP_LOW_CAP_W-1:0] = LOW_CAP;
         w[`PDCAP_BIT_ATTN_LAMP] = `PDCAP_ATTN_LAMP_VAL; // [R1]
         w[`PDCAP_BIT_PWR_LAMP]  = `PDCAP_PWR_LAMP_VAL;  // [R2]
         w[`PDCAP_BIT_ROLE_ERR]  = `PDCAP_ROLE_ERR_VAL;  // [R3]
         if (show) begin // [R7]
            w[`PDCAP_CPV_MSB:`PDCAP_CPV_LSB] = capt[`PDCAP_VALUE_W-1:0];
            w[`PDCAP_CPS_MSB:`PDCAP_CPS_LSB] = capt[`PDCAP_CAPT_W-1:`PDCAP_VALUE_W];
         end
         devcap_word = w;
      end
   endfunction

   // limit in hundredths of a watt; 15 bits hold 255 x 100, the finest scale rounds down
   function [14:0] centi_watts;
      input [`PDCAP_CAPT_W-1:0] capt;
      reg   [`PDCAP_VALUE_W-1:0] v;
      begin
         v = capt[`PDCAP_VALUE_W-1:0];
         case (capt[`PDCAP_CAPT_W-1:`PDCAP_VALUE_W]) // [R5]
            `PDCAP_SCALE_X1:     centi_watts = {7'h00, v} * 15'h0064;
            `PDCAP_SCALE_X0P1:   centi_watts = {7'h00, v} * 15'h000A;
            `PDCAP_SCALE_X0P01:  centi_watts = {7'h00, v};
            `PDCAP_SCALE_X0P001: centi_watts = {7'h00, v} / 15'h000A;
            default:             centi_watts = 15'h0000;
         endcase
      end
   endfunction

   // port role, decided from the type code
   wire is_upstream   = (port_type == `PDCAP_TYPE_UPSTREAM);   // [R12]
   wire is_downstream = (port_type == `PDCAP_TYPE_DOWNSTREAM); // [R12]

   // capture applies only to an attached upstream port
   wire capture_allow = is_upstream & ~unattached; // [R4] [R6]
   // downstream or unattached ports hide the captured fields
   wire show_capt     = capture_allow & ~is_downstream; // [R7]

   wire hit_cap_wr = cfg_wr & addr_hit(cfg_addr, `PDCAP_OFF_DEVCAP);
   wire hit_ctl_wr = cfg_wr & addr_hit(cfg_addr, `PDCAP_OFF_DEVCTL);
   wire hit_cap_rd = cfg_rd & addr_hit(cfg_addr, `PDCAP_OFF_DEVCAP);
   wire hit_ctl_rd = cfg_rd & addr_hit(cfg_addr, `PDCAP_OFF_DEVCTL);

   // error reporting enables, one set for the port
   reg  [2:0] ctl_enable_r;
   reg  [2:0] ctl_enable_nxt;

   always @* begin
      ctl_enable_nxt = ctl_enable_r;
      if (hit_ctl_wr) begin
         ctl_enable_nxt[`PDCAP_BIT_CORR_EN]     = cfg_wdata[`PDCAP_BIT_CORR_EN];     // [R9]
         ctl_enable_nxt[`PDCAP_BIT_NONFATAL_EN] = cfg_wdata[`PDCAP_BIT_NONFATAL_EN]; // [R10]
         ctl_enable_nxt[`PDCAP_BIT_FATAL_EN]    = cfg_wdata[`PDCAP_BIT_FATAL_EN];    // [R11]
      end
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_enable_r <= `PDCAP_DEVCTL_RESET; // [R9] [R10] [R11]
      end else begin
         ctl_enable_r <= ctl_enable_nxt;
      end
   end

   // writes to the capabilities word change no field, but clear cfg_rdata on the next edge
   wire cap_write_dropped = hit_cap_wr; // [R13]

   wire [NUM_FUNC*`PDCAP_CAPT_W-1:0] capt_flat;

   pdcap_spl_capture #(
      .NUM_FUNC      (NUM_FUNC)
   ) u_capture (
      .sys_clk       (sys_clk),
      .reset_n       (reset_n),
      .msg_valid     (spl_msg_valid),
      .msg_value     (spl_msg_value),
      .msg_scale     (spl_msg_scale),
      .capture_allow (capture_allow),
      .capt_flat     (capt_flat),
      .captured_r    (spl_captured)
   );

   wire [2:0] err_report;

   pdcap_err_gate u_err_gate (
      .sys_clk       (sys_clk),
      .reset_n       (reset_n),
      .report_enable (ctl_enable_r),
      .err_event     ({err_fatal_evt, err_nonfatal_evt, err_corr_evt}),
      .err_report_r  (err_report)
   );

   assign corr_report     = err_report[`PDCAP_BIT_CORR_EN];     // [R9]
   assign nonfatal_report = err_report[`PDCAP_BIT_NONFATAL_EN]; // [R10]
   assign fatal_report    = err_report[`PDCAP_BIT_FATAL_EN];    // [R11]

   // the addressed function's captured fields; out-of-range numbers see zero
   reg [`PDCAP_CAPT_W-1:0] sel_capt;
   integer k;

   always @* begin
      sel_capt = {`PDCAP_CAPT_W{1'b0}};
      for (k = 0; k < NUM_FUNC; k = k + 1) begin
         if (cfg_func == k[FUNC_W-1:0]) begin
            sel_capt = capt_flat[k*`PDCAP_CAPT_W +: `PDCAP_CAPT_W];
         end
      end
   end

   // read data stands for exactly one cycle after the strobe
   reg [31:0] rdata_nxt;

   always @* begin
      rdata_nxt = 32'h0000_0000;
      if (hit_cap_rd) begin
         rdata_nxt = devcap_word(sel_capt, show_capt); // [R7] [R13]
      end else if (hit_ctl_rd) begin
         rdata_nxt[2:0] = ctl_enable_r;
      end
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_rdata <= 32'h0000_0000;
      end else if (cap_write_dropped) begin
         cfg_rdata <= 32'h0000_0000;
      end else begin
         cfg_rdata <= rdata_nxt;
      end
   end

   // function 0 fields as software would see them, for power budgeting logic
   wire [`PDCAP_CAPT_W-1:0] capt0 = capt_flat[`PDCAP_CAPT_W-1:0];

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         captured_power_value <= 8'h00;
         captured_power_scale <= 2'h0;
         power_limit_centi    <= 15'h0000;
      end else if (show_capt) begin // [R7]
         captured_power_value <= capt0[`PDCAP_VALUE_W-1:0];
         captured_power_scale <= capt0[`PDCAP_CAPT_W-1:`PDCAP_VALUE_W];
         power_limit_centi    <= centi_watts(capt0); // [R5]
      end else begin
         captured_power_value <= 8'h00;
         captured_power_scale <= 2'h0;
         power_limit_centi    <= 15'h0000;
      end
   end

endmodule // pdcap_port_regs

// [testbench/pdcap_link_partner.sv]
`timescale 1ns/10ps
module pdcap_link_partner (
   input  wire       sys_clk,   // core clock
   output reg        msg_valid, // message strobe
   output reg  [7:0] msg_value, // power value
   output reg  [1:0] msg_scale  // power scale
);
   initial begin
      msg_valid = 1'b0;
      msg_value = 8'h00;
      msg_scale = 2'h0;
   end
   // fields turn to their inverse once the strobe is gone
   task send_msg(input [7:0] v, input [1:0] s);
      begin
         @(posedge sys_clk);
         msg_valid <= 1'b1;
         msg_value <= v;
         msg_scale <= s;
         @(posedge sys_clk);
         msg_valid <= 1'b0;
         msg_value <= ~v;
         msg_scale <= ~s;
      end
   endtask
endmodule // pdcap_link_partner

// [testbench/pdcap_port_regs_monitor.sv]
`timescale 1ns/10ps
`include "pdcap_defines.vh"
module pdcap_port_regs_monitor (
   input wire        sys_clk,              // clock
   input wire        reset_n,              // reset
   input wire [11:0] cfg_addr,             // address
   input wire [31:0] cfg_wdata,            // write data
   input wire        cfg_wr,               // write
   input wire        cfg_rd,               // read
   input wire [31:0] cfg_rdata,            // read data
   input wire [3:0]  port_type,            // port type
   input wire        unattached,           // unattached
   input wire        spl_msg_valid,        // message
   input wire [7:0]  spl_msg_value,        // value
   input wire [1:0]  spl_msg_scale,        // scale
   input wire        err_corr_evt,         // event
   input wire        err_nonfatal_evt,     // event
   input wire        err_fatal_evt,        // event
   input wire        corr_report,          // report
   input wire        nonfatal_report,      // report
   input wire        fatal_report,         // report
   input wire        spl_captured,         // capture pulse
   input wire [7:0]  captured_power_value, // value out
   input wire [1:0]  captured_power_scale, // scale out
   input wire [14:0] power_limit_centi     // limit out
);
   reg  [2:0] en_r;
   reg  [2:0] gate_r;
   wire       off_w  = port_type != `PDCAP_TYPE_UPSTREAM || unattached;
   wire       rd_cap = cfg_rd && cfg_addr == `PDCAP_OFF_DEVCAP;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // mirror of the enables and the reports they allow
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         en_r   <= 3'h0;
         gate_r <= 3'h0;
      end else begin
         if (cfg_wr && cfg_addr == `PDCAP_OFF_DEVCTL)
            en_r <= cfg_wdata[2:0];
         gate_r <= {err_fatal_evt, err_nonfatal_evt, err_corr_evt} & en_r;
      end
   end
   function [14:0] centi(input [7:0] v, input [1:0] s);
      case (s)
         2'h0: centi = {7'h00, v} * 15'h0064;
         2'h1: centi = {7'h00, v} * 15'h000A;
         2'h2: centi = {7'h00, v};
         default: centi = {7'h00, v / 8'h0A};
      endcase
   endfunction
   sequence msg_taken;
      spl_msg_valid && !off_w;
   endsequence
   sequence fields_follow;
      spl_captured ##1 captured_power_value == $past(spl_msg_value, 2)
         && captured_power_scale == $past(spl_msg_scale, 2);
   endsequence
   lamp_bits_a: assert property (rd_cap |=> cfg_rdata[14:13] == 2'h0)
      else $error("lamp bits not zero");
   role_bit_a: assert property (rd_cap |=> cfg_rdata[15])
      else $error("role error bit not one");
   capture_load_a: assert property (msg_taken ##1 !off_w |-> fields_follow)
      else $error("message not captured");
   no_capture_a: assert property (spl_msg_valid && off_w |=> !spl_captured)
      else $error("message captured while barred");
   fields_zero_a: assert property (off_w |=> captured_power_value == 8'h00
      && captured_power_scale == 2'h0) else $error("captured fields not zero");
   read_zero_a: assert property (rd_cap && off_w |=> cfg_rdata[27:18] == 10'h000)
      else $error("captured read not zero");
   ctl_read_a: assert property (cfg_rd && cfg_addr == `PDCAP_OFF_DEVCTL
      |=> cfg_rdata == {29'h0, en_r}) else $error("control read wrong");
   err_gate_a: assert property ({fatal_report, nonfatal_report, corr_report} == gate_r)
      else $error("error report gating wrong");
   limit_scale_a: assert property (power_limit_centi == centi(captured_power_value,
      captured_power_scale)) else $error("power limit scaling wrong");
endmodule // pdcap_port_regs_monitor
bind pdcap_port_regs pdcap_port_regs_monitor i_mon (
   .sys_clk(sys_clk), .reset_n(reset_n), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
   .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .port_type(port_type),
   .unattached(unattached), .spl_msg_valid(spl_msg_valid), .spl_msg_value(spl_msg_value),
   .spl_msg_scale(spl_msg_scale), .err_corr_evt(err_corr_evt),
   .err_nonfatal_evt(err_nonfatal_evt), .err_fatal_evt(err_fatal_evt),
   .corr_report(corr_report), .nonfatal_report(nonfatal_report),
   .fatal_report(fatal_report), .spl_captured(spl_captured),
   .captured_power_value(captured_power_value), .captured_power_scale(captured_power_scale),
   .power_limit_centi(power_limit_centi));

// [testbench/tb.sv]
`timescale 1ns/10ps
`include "pdcap_defines.vh"
module tb;
   localparam [12:0] LOW = 13'h1A5A;
   reg         sys_clk = 1'b0;
   reg         reset_n = 1'b0;
   reg  [11:0] cfg_addr = 12'h000;
   reg         cfg_func = 1'b0;
   reg  [31:0] cfg_wdata = 32'h0000_0000;
   reg         cfg_wr = 1'b0;
   reg         cfg_rd = 1'b0;
   reg  [3:0]  port_type = `PDCAP_TYPE_UPSTREAM;
   reg         unattached = 1'b0;
   reg  [2:0]  evt = 3'h0;
   wire [31:0] cfg_rdata;
   wire        msg_valid, spl_captured, corr_rep, nf_rep, fat_rep;
   wire [7:0]  msg_value, cap_val;
   wire [1:0]  msg_scale, cap_scl;
   wire [14:0] lim;
   integer     bad_count = 0, checked = 0, cycles = 0, i, s;
   pdcap_link_partner i_pdcap_link_partner (.sys_clk(sys_clk), .msg_valid(msg_valid),
      .msg_value(msg_value), .msg_scale(msg_scale));
   pdcap_port_regs #(.NUM_FUNC(2), .FUNC_W(1), .LOW_CAP(LOW)) i_pdcap_port_regs (
      .sys_clk(sys_clk), .reset_n(reset_n), .cfg_addr(cfg_addr), .cfg_func(cfg_func),
      .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
      .port_type(port_type), .unattached(unattached), .spl_msg_valid(msg_valid),
      .spl_msg_value(msg_value), .spl_msg_scale(msg_scale), .err_corr_evt(evt[0]),
      .err_nonfatal_evt(evt[1]), .err_fatal_evt(evt[2]), .corr_report(corr_rep),
      .nonfatal_report(nf_rep), .fatal_report(fat_rep), .spl_captured(spl_captured),
      .captured_power_value(cap_val), .captured_power_scale(cap_scl), .power_limit_centi(lim));
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         bad_count = bad_count + 1;
         complete_run;
      end
   end
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", checked, bad_count);
         if (bad_count == 0 && checked > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      begin
         @(posedge sys_clk);
         cfg_wr <= 1'b1;
         cfg_addr <= a;
         cfg_wdata <= d;
         @(posedge sys_clk);
         cfg_wr <= 1'b0;
      end
   endtask
   task rd(input [11:0] a, input f, input [31:0] exp);
      begin
         @(posedge sys_clk);
         cfg_rd <= 1'b1;
         cfg_addr <= a;
         cfg_func <= f;
         @(posedge sys_clk);
         cfg_rd <= 1'b0;
         #1 chk(cfg_rdata, exp);
      end
   endtask
   task msg(input [7:0] v, input [1:0] sc, input ok);
      begin
         i_pdcap_link_partner.send_msg(v, sc);
         #1 chk({31'h0, spl_captured}, {31'h0, ok});
      end
   endtask
   // limits in 0.01 W for the values 0x19 to 0x1C that the scale loop sends
   function [31:0] lim_exp(input integer sc);
      case (sc)
         0: lim_exp = 32'h0000_09C4;
         1: lim_exp = 32'h0000_0104;
         2: lim_exp = 32'h0000_001B;
         default: lim_exp = 32'h0000_0002;
      endcase
   endfunction
   function [31:0] capw(input [7:0] v, input [1:0] sc);
      capw = {4'h0, sc, v, 2'h0, 1'b1, 2'h0, LOW};
   endfunction
   initial begin
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(`PDCAP_OFF_DEVCAP, 1'b0, capw(8'h00, 2'h0));
      rd(`PDCAP_OFF_DEVCTL, 1'b0, 32'h0000_0000);
      wr(12'h04C, 32'hFFFF_FFFF);
      rd(12'h04C, 1'b0, 32'h0000_0000);
      $display("test 1 done");
      for (i = 0; i < 8; i = i + 1) begin
         wr(`PDCAP_OFF_DEVCTL, 32'hFFFF_FFF8 | i);
         @(posedge sys_clk);
         evt <= 3'h7;
         @(posedge sys_clk);
         evt <= 3'h0;
         #1 chk({fat_rep, nf_rep, corr_rep}, i);
         rd(`PDCAP_OFF_DEVCTL, 1'b0, i);
      end
      $display("test 2 done");
      msg(8'hFF, 2'h0, 1'b1);
      @(posedge sys_clk);
      #1 chk({17'h0, lim}, 32'h0000_639C);
      for (s = 0; s < 4; s = s + 1) begin
         msg(8'h19 + s[7:0], s[1:0], 1'b1);
         @(posedge sys_clk);
         #1 chk({cap_scl, cap_val}, {s[1:0], 8'h19 + s[7:0]});
         chk({17'h0, lim}, lim_exp(s));
         rd(`PDCAP_OFF_DEVCAP, 1'b1, capw(8'h19 + s[7:0], s[1:0]));
      end
      wr(`PDCAP_OFF_DEVCAP, 32'hFFFF_FFFF);
      rd(`PDCAP_OFF_DEVCAP, 1'b0, capw(8'h1C, 2'h3));
      $display("test 3 done");
      @(posedge sys_clk);
      unattached <= 1'b1;
      msg(8'h77, 2'h2, 1'b0);
      rd(`PDCAP_OFF_DEVCAP, 1'b0, capw(8'h00, 2'h0));
      @(posedge sys_clk);
      unattached <= 1'b0;
      rd(`PDCAP_OFF_DEVCAP, 1'b1, capw(8'h1C, 2'h3));
      $display("test 4 done");
      @(posedge sys_clk);
      port_type <= `PDCAP_TYPE_DOWNSTREAM;
      msg(8'h42, 2'h0, 1'b0);
      rd(`PDCAP_OFF_DEVCAP, 1'b0, capw(8'h00, 2'h0));
      @(posedge sys_clk);
      port_type <= `PDCAP_TYPE_UPSTREAM;
      rd(`PDCAP_OFF_DEVCAP, 1'b0, capw(8'h1C, 2'h3));
      $display("test 5 done");
      complete_run;
   end
endmodule // tb
